// ===== core/clbm_pkg.sv
// Behaviour
// - supervise only heating or cooling channels, never alarm channels
// - heating expects input rising at full power, falling at zero power
// - cooling expects input falling at full power, rising at zero power
// - output reaching an extreme starts the timer and latches the input
// - the input at the extreme is kept as the band check baseline
// - input moving the band away before expiry clears the timer
// - each band step at the same extreme re-latches input, restarts timing
// - any output level change resets the timer
// - timer held cleared while output sits between extremes
// - expiry without movement latches fault, lights status, stops control
// - on fault outputs are forced to the error-mode output state
// - restart delay is off or 1 to 999 seconds, off by default
// - with restart off, operator must go stop or manual, then auto
// - break time set to off disables supervision on that channel
package clbm_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam longint TICK_PERIOD_NS = 1000000000;
  localparam int TICK_CYCLES = int'(TICK_PERIOD_NS / CLK_PERIOD_NS);
  localparam int PV_W = 16;
  localparam int OUT_W = 10;
  localparam logic [OUT_W-1:0] OUT_FULL = 10'h3E8;
  // register map, per channel block of 0x20 bytes
  localparam int CH_SHIFT = 5;
  localparam logic [4:0] REG_CFG = 5'h00;
  localparam logic [4:0] REG_BRK_TIME = 5'h04;
  localparam logic [4:0] REG_BAND = 5'h08;
  localparam logic [4:0] REG_RESTART = 5'h0C;
  localparam logic [4:0] REG_MODE = 5'h10;
  localparam logic [4:0] REG_STATUS = 5'h14;
  // field positions and codes
  localparam int CFG_ERR_ON_BIT = 2;
  localparam int STAT_STATE_LSB = 1;
  localparam int STAT_TIMER_LSB = 16;
  localparam logic [1:0] LOGIC_HEAT = 2'h0;
  localparam logic [1:0] LOGIC_COOL = 2'h1;
  localparam logic [1:0] OP_STOP = 2'h0;
  localparam logic [1:0] OP_MAN = 2'h1;
  localparam logic [1:0] OP_AUTO = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // limits and reset values
  localparam logic [13:0] BRK_TIME_MAX = 14'h270F;
  localparam logic [9:0] RESTART_MAX = 10'h3E7;
  localparam logic [1:0] CFG_LOGIC_RST = LOGIC_HEAT;
  localparam logic CFG_ERR_ON_RST = 1'b0;
  localparam logic [13:0] BRK_TIME_RST = 14'h0000;
  localparam logic [PV_W-1:0] BAND_RST = 16'h000A;
  localparam logic [9:0] RESTART_RST = 10'h000;
  localparam logic [1:0] OP_RST = OP_STOP;

  typedef enum logic [2:0] {
    M_STOP, M_MAN, M_AUTO, M_HALT, M_BREAK
  } clbm_mode_t;

  typedef struct packed {
    logic [PV_W-1:0] pv;
    logic pv_valid;
    logic [OUT_W-1:0] out_level;
  } clbm_ch_in_t;

  typedef struct packed {
    logic run;
    logic ovr;
    logic ovr_on;
    logic led;
  } clbm_ch_out_t;

  typedef struct packed {
    logic [1:0] cfg_logic;
    logic err_on;
    logic [13:0] brk_time;
    logic [PV_W-1:0] band;
    logic [9:0] rst_dly;
    logic [1:0] op;
    clbm_mode_t mode;
    logic fault;
    logic [PV_W-1:0] ref_pv;
    logic [OUT_W-1:0] prev_out;
    logic [13:0] btimer;
    logic [9:0] rtimer;
    clbm_ch_out_t out;
  } clbm_ch_t;

  // signed difference of two unsigned readings
  function automatic logic signed [PV_W:0] clbm_sub(
    input logic [PV_W-1:0] a,
    input logic [PV_W-1:0] b
  );
    clbm_sub = $signed({1'b0, a}) - $signed({1'b0, b});
  endfunction

  // byte-lane merge of a write into an old word
  function automatic logic [31:0] clbm_merge(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [3:0] strb
  );
    for (int k = 0; k < 4; k++)
    begin
      clbm_merge[8*k +: 8] = strb[k] ? wd[8*k +: 8] : old[8*k +: 8];
    end
  endfunction
endpackage

// ===== core/clbm_tick.sv
`timescale 1ns/1ps
`default_nettype none
module clbm_tick #(
  parameter int DIV = 100000000
) (
  input wire logic aclk,
  input wire logic aresetn,
  output logic tick
);
  localparam int CW = $clog2(DIV);
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } clbm_tick_st_t;
  clbm_tick_st_t s;
  clbm_tick_st_t next_s;

  if (DIV < 2)
  begin : g_chk
    $error("clbm_tick: DIV must be at least 2");
  end

  // free-running divider, one-cycle pulse per period
  always_comb
  begin
    next_s = s;
    next_s.tick = 1'b0;
    if (s.cnt == CW'(DIV - 1))
    begin
      next_s.cnt = '0;
      next_s.tick = 1'b1;
    end
    else
    begin
      next_s.cnt = s.cnt + 1'b1;
    end
  end

  // state register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s <= '0;
    else
      s <= next_s;
  end

  assign tick = s.tick;
endmodule
`default_nettype wire

// ===== core/clbm_top.sv
`timescale 1ns/1ps
`default_nettype none
module clbm_top
  import clbm_pkg::*;
#(
  parameter int NCH = 2,
  parameter int TICK_DIV = clbm_pkg::TICK_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire clbm_pkg::clbm_ch_in_t [NCH-1:0] ch_in,
  input wire logic [NCH-1:0] fault_keep,
  output clbm_pkg::clbm_ch_out_t [NCH-1:0] ch_out,
  output logic [NCH-1:0] fault_store
);
  typedef struct packed {
    logic init;
    clbm_ch_t [NCH-1:0] ch;
    logic [7:0] awaddr;
    logic aw_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic w_got;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [NCH-1:0] fstore;
  } clbm_st_t;

  clbm_st_t s;
  clbm_st_t next_s;
  logic tick;

  if (NCH < 1 || NCH > 4)
  begin : g_chk
    $error("clbm_top: NCH must be 1 to 4");
  end

  // seconds tick shared by all channel timers
  clbm_tick #(.DIV(TICK_DIV)) u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick)
  );

  // register word as software sees it
  function automatic logic [31:0] reg_word(
    input clbm_ch_t c,
    input logic [4:0] off
  );
    reg_word = '0;
    case (off)
      REG_CFG: reg_word = 32'({c.err_on, c.cfg_logic});
      REG_BRK_TIME: reg_word = 32'(c.brk_time);
      REG_BAND: reg_word = 32'(c.band);
      REG_RESTART: reg_word = 32'(c.rst_dly);
      REG_MODE: reg_word = 32'(c.op);
      REG_STATUS:
      begin
        reg_word[0] = c.fault;
        reg_word[STAT_STATE_LSB +: 3] = c.mode;
        reg_word[STAT_TIMER_LSB +: 14] = c.btimer;
      end
      default: reg_word = '0;
    endcase
  endfunction

  // mode chosen by the operator setting outside auto
  function automatic clbm_mode_t follow_op(input logic [1:0] op);
    follow_op = (op == OP_MAN) ? M_MAN : M_STOP;
  endfunction

  // bus slave, register writes and per-channel supervision
  always_comb
  begin
    logic [1:0] wch;
    logic [4:0] woff;
    logic [31:0] wv;
    logic werr;
    logic [1:0] rch;
    logic sup;
    logic ext;
    logic want_rise;
    logic moved;
    logic [PV_W-1:0] pv;
    logic [OUT_W-1:0] ol;
    wch = s.awaddr[CH_SHIFT +: 2];
    woff = s.awaddr[4:0];
    wv = '0;
    werr = 1'b0;
    rch = s_axi_araddr[CH_SHIFT +: 2];
    sup = 1'b0;
    ext = 1'b0;
    want_rise = 1'b0;
    moved = 1'b0;
    pv = '0;
    ol = '0;
    next_s = s;
    next_s.init = 1'b0;

    // write address and data taken in either order
    if (s_axi_awvalid && s.awready)
    begin
      next_s.awaddr = s_axi_awaddr;
      next_s.aw_got = 1'b1;
      next_s.awready = 1'b0;
    end
    if (s_axi_wvalid && s.wready)
    begin
      next_s.wdata = s_axi_wdata;
      next_s.wstrb = s_axi_wstrb;
      next_s.w_got = 1'b1;
      next_s.wready = 1'b0;
    end
    if (s.bvalid && s_axi_bready)
    begin
      next_s.bvalid = 1'b0;
      next_s.awready = 1'b1;
      next_s.wready = 1'b1;
    end

    // perform a write once both halves are held
    if (s.aw_got && s.w_got && !s.bvalid)
    begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      werr = (32'(wch) >= NCH) || (s.awaddr[1:0] != 2'h0);
      if (!werr)
      begin
        wv = clbm_merge(reg_word(s.ch[wch], woff), s.wdata, s.wstrb);
        case (woff)
          REG_CFG:
          begin
            next_s.ch[wch].cfg_logic = wv[1:0];
            next_s.ch[wch].err_on = wv[CFG_ERR_ON_BIT];
          end
          REG_BRK_TIME: next_s.ch[wch].brk_time =
            (wv[31:0] > 32'(BRK_TIME_MAX)) ? BRK_TIME_MAX : wv[13:0];
          REG_BAND: next_s.ch[wch].band = wv[PV_W-1:0];
          // restart delay saturates at its upper limit
          REG_RESTART: next_s.ch[wch].rst_dly =
            (wv[31:0] > 32'(RESTART_MAX)) ? RESTART_MAX : wv[9:0];
          REG_MODE: next_s.ch[wch].op = wv[1:0];
          default: werr = 1'b1;
        endcase
      end
      next_s.bresp = werr ? RESP_SLVERR : RESP_OKAY;
    end

    // reads answer one cycle after the address is taken
    if (s_axi_arvalid && s.arready)
    begin
      next_s.arready = 1'b0;
      next_s.rvalid = 1'b1;
      if ((32'(rch) < NCH) && (s_axi_araddr[1:0] == 2'h0)
          && (s_axi_araddr[4:0] <= REG_STATUS))
      begin
        next_s.rdata = reg_word(s.ch[rch], s_axi_araddr[4:0]);
        next_s.rresp = RESP_OKAY;
      end
      else
      begin
        next_s.rdata = '0;
        next_s.rresp = RESP_SLVERR;
      end
    end
    if (s.rvalid && s_axi_rready)
    begin
      next_s.rvalid = 1'b0;
      next_s.arready = 1'b1;
    end

    // per-channel mode machine and break supervision
    for (int i = 0; i < NCH; i++)
    begin
      pv = ch_in[i].pv;
      ol = ch_in[i].out_level;
      next_s.ch[i].prev_out = ol;
      sup = (s.ch[i].brk_time != '0) && !s.ch[i].cfg_logic[1];
      ext = (ol == OUT_FULL) || (ol == '0);
      want_rise = (s.ch[i].cfg_logic == LOGIC_HEAT) ? (ol == OUT_FULL)
                                                    : (ol == '0);
      moved = want_rise
        ? (clbm_sub(pv, s.ch[i].ref_pv) >= $signed({1'b0, s.ch[i].band}))
        : (clbm_sub(s.ch[i].ref_pv, pv) >= $signed({1'b0, s.ch[i].band}));
      if (s.init)
      begin
        // fault kept in retained storage survives power-on
        if (fault_keep[i])
        begin
          next_s.ch[i].fault = 1'b1;
          next_s.ch[i].mode = M_BREAK;
          // back in auto, so a stop or manual step is still needed
          next_s.ch[i].op = OP_AUTO;
        end
      end
      else
      begin
        case (s.ch[i].mode)
          M_STOP, M_MAN:
          begin
            next_s.ch[i].btimer = '0;
            next_s.ch[i].ref_pv = pv;
            if (s.ch[i].op == OP_AUTO)
              next_s.ch[i].mode = M_AUTO;
            else
              next_s.ch[i].mode = follow_op(s.ch[i].op);
          end
          M_AUTO:
          begin
            if (s.ch[i].op != OP_AUTO)
              next_s.ch[i].mode = follow_op(s.ch[i].op);
            else if (!ch_in[i].pv_valid)
            begin
              next_s.ch[i].mode = M_HALT;
              next_s.ch[i].rtimer = '0;
            end
            else if (!sup || !ext || ol != s.ch[i].prev_out)
            begin
              // level change or mid level: clear and re-latch
              next_s.ch[i].btimer = '0;
              next_s.ch[i].ref_pv = pv;
            end
            else if (moved)
            begin
              next_s.ch[i].btimer = '0;
              next_s.ch[i].ref_pv = pv;
            end
            else if (tick)
            begin
              if (s.ch[i].btimer + 14'h0001 >= s.ch[i].brk_time)
              begin
                next_s.ch[i].fault = 1'b1;
                next_s.ch[i].mode = M_BREAK;
              end
              else
                next_s.ch[i].btimer = s.ch[i].btimer + 14'h0001;
            end
          end
          M_HALT:
          begin
            if (s.ch[i].op != OP_AUTO)
              next_s.ch[i].mode = follow_op(s.ch[i].op);
            else if (!ch_in[i].pv_valid || s.ch[i].rst_dly == '0)
              next_s.ch[i].rtimer = '0;
            else if (tick)
            begin
              if (s.ch[i].rtimer + 10'h001 >= s.ch[i].rst_dly)
              begin
                next_s.ch[i].mode = M_AUTO;
                next_s.ch[i].btimer = '0;
                next_s.ch[i].ref_pv = pv;
              end
              else
                next_s.ch[i].rtimer = s.ch[i].rtimer + 10'h001;
            end
          end
          M_BREAK:
          begin
            // only leaving auto clears the break fault
            if (s.ch[i].op != OP_AUTO)
            begin
              next_s.ch[i].fault = 1'b0;
              next_s.ch[i].mode = follow_op(s.ch[i].op);
            end
          end
          default: next_s.ch[i].mode = M_STOP;
        endcase
      end
      // registered outputs follow the next state
      next_s.ch[i].out.run = next_s.ch[i].mode == M_AUTO;
      next_s.ch[i].out.ovr = (next_s.ch[i].mode == M_STOP)
        || (next_s.ch[i].mode == M_HALT) || (next_s.ch[i].mode == M_BREAK);
      next_s.ch[i].out.ovr_on = ((next_s.ch[i].mode == M_BREAK)
        || (next_s.ch[i].mode == M_HALT)) && next_s.ch[i].err_on;
      next_s.ch[i].out.led = next_s.ch[i].fault;
      next_s.fstore[i] = next_s.ch[i].fault;
    end
  end

  // state register with synchronous reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s <= '0;
      s.init <= 1'b1;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
      for (int i = 0; i < NCH; i++)
      begin
        s.ch[i].cfg_logic <= CFG_LOGIC_RST;
        s.ch[i].err_on <= CFG_ERR_ON_RST;
        s.ch[i].brk_time <= BRK_TIME_RST;
        s.ch[i].band <= BAND_RST;
        s.ch[i].rst_dly <= RESTART_RST;
        s.ch[i].op <= OP_RST;
        s.ch[i].mode <= M_STOP;
        s.ch[i].out.ovr <= 1'b1;
      end
    end
    else
      s <= next_s;
  end

  // outputs straight from the state register
  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign fault_store = s.fstore;
  for (genvar g = 0; g < NCH; g++)
  begin : g_out
    assign ch_out[g] = s.ch[g].out;
  end

  // checks on channel 0 and the bus
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_alarm_no_sup: assert property (
    s.ch[0].mode == M_AUTO && s.ch[0].cfg_logic[1] |=> !s.ch[0].fault)
    else $error("alarm channel got a break fault");
  a_heat_rise_ok: assert property (
    s.ch[0].mode == M_AUTO && s.ch[0].op == OP_AUTO && ch_in[0].pv_valid
    && s.ch[0].cfg_logic == LOGIC_HEAT && s.ch[0].brk_time != '0
    && ch_in[0].out_level == OUT_FULL && s.ch[0].prev_out == OUT_FULL
    && clbm_sub(ch_in[0].pv, s.ch[0].ref_pv) >= $signed({1'b0, s.ch[0].band})
    |=> s.ch[0].btimer == '0 && s.ch[0].ref_pv == $past(ch_in[0].pv))
    else $error("heating rise did not restart timing");
  a_edge_latch: assert property (
    s.ch[0].mode == M_AUTO && s.ch[0].op == OP_AUTO && ch_in[0].pv_valid
    && ch_in[0].out_level != s.ch[0].prev_out
    |=> s.ch[0].btimer == '0 && s.ch[0].ref_pv == $past(ch_in[0].pv))
    else $error("output change did not latch reference");
  a_mid_clear: assert property (
    s.ch[0].mode == M_AUTO && ch_in[0].out_level != '0
    && ch_in[0].out_level != OUT_FULL ##1 s.ch[0].mode == M_AUTO
    |-> s.ch[0].btimer == '0)
    else $error("timer ran at intermediate output");
  a_fault_led: assert property (
    s.ch[0].mode == M_BREAK |-> ch_out[0].led && !ch_out[0].run)
    else $error("break without status led");
  a_fault_safe: assert property (
    s.ch[0].mode == M_BREAK |-> ch_out[0].ovr
    && ch_out[0].ovr_on == s.ch[0].err_on)
    else $error("break outputs not in error state");
  a_halt_resume: assert property (
    s.ch[0].mode == M_HALT && s.ch[0].op == OP_AUTO && ch_in[0].pv_valid
    && s.ch[0].rst_dly != '0 && tick
    && s.ch[0].rtimer + 10'h001 >= s.ch[0].rst_dly |=> s.ch[0].mode == M_AUTO)
    else $error("auto restart did not resume");
  a_delay_limit: assert property (
    s.ch[0].rst_dly <= RESTART_MAX)
    else $error("restart delay above limit");
  a_restart_off: assert property (
    s.ch[0].mode == M_HALT && s.ch[0].rst_dly == '0
    |=> s.ch[0].mode != M_AUTO)
    else $error("resumed with restart off");
  a_fault_hold: assert property (
    s.ch[0].fault && s.ch[0].op == OP_AUTO |=> s.ch[0].fault)
    else $error("break fault cleared in auto");
  a_tick_count: assert property (
    s.ch[0].btimer != '0 && $changed(s.ch[0].btimer) |-> $past(tick))
    else $error("break timer moved without tick");
  a_keep_fault: assert property (
    s.init && fault_keep[0] |=> s.ch[0].fault ##1 fault_store[0])
    else $error("retained fault lost at start");
  a_bvalid_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  c_break: cover property (s.ch[0].mode == M_AUTO ##1 s.ch[0].mode == M_BREAK);
  c_restart: cover property (s.ch[0].mode == M_HALT ##1 s.ch[0].mode == M_AUTO);
  c_clear: cover property (s.ch[0].mode == M_BREAK ##1 s.ch[0].mode == M_STOP);
endmodule
`default_nettype wire

// ===== dv/clbm_plant.sv
`timescale 1ns/1ps
`default_nettype none
module clbm_plant #(
  parameter int STEP_DIV = 10
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [clbm_pkg::OUT_W-1:0] out_level,
  input wire logic cool,
  input wire logic stuck,
  output logic [clbm_pkg::PV_W-1:0] pv
);
  import clbm_pkg::*;
  int cnt;
  logic up;
  logic ext;
  // heater pushes the reading up at full power, a cooler pushes it down
  assign up = (out_level == OUT_FULL) ^ cool;
  assign ext = (out_level == OUT_FULL) || (out_level == '0);
  // one step of 5 every STEP_DIV cycles at an extreme; stuck models a break
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt <= 0;
      pv <= 16'h0100;
    end
    else
    begin
      cnt <= (cnt == STEP_DIV - 1) ? 0 : cnt + 1;
      if (cnt == 0 && !stuck && ext)
        pv <= up ? pv + 16'h0005 : pv - 16'h0005;
    end
  end
endmodule
`default_nettype wire

// ===== dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import clbm_pkg::*;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, vld, cool_p, stuck, hit;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r, fault_keep, fault_store;
  logic [OUT_W-1:0] lvl;
  logic [PV_W-1:0] pv;
  clbm_ch_in_t [1:0] ch_in;
  clbm_ch_out_t [1:0] ch_out;
  int err_total, compares;
  // channel 0 follows the plant, channel 1 stays idle in stop
  assign ch_in[0] = '{pv: pv, pv_valid: vld, out_level: lvl};
  assign ch_in[1] = '{pv: 16'h0200, pv_valid: 1'b1, out_level: 10'h3E8};
  clbm_plant plant (.aclk(aclk), .aresetn(aresetn), .out_level(lvl),
    .cool(cool_p), .stuck(stuck), .pv(pv));
  clbm_top #(.NCH(2), .TICK_DIV(20)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .ch_in(ch_in), .fault_keep(fault_keep),
    .ch_out(ch_out), .fault_store(fault_store));
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // write one word, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
    output logic [1:0] resp);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge aclk);
      if (!aw_ok && awready)
      begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready)
      begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v,
    output logic [1:0] resp);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  // watch the status light of channel 0 for n cycles
  task automatic watch(input int n, output logic seen);
    seen = 1'b0;
    repeat (n)
    begin
      @(posedge aclk);
      if (ch_out[0].led === 1'b1)
        seen = 1'b1;
    end
  endtask
  // configure channel 0, set the plant, then stop and back to auto
  task automatic arm(input logic [31:0] cfg, input logic [31:0] bt,
    input logic c, input logic s, input logic [9:0] l);
    cool_p <= c;
    stuck <= s;
    lvl <= l;
    wr({3'h0, REG_CFG}, cfg, r);
    wr({3'h0, REG_BRK_TIME}, bt, r);
    wr({3'h0, REG_MODE}, 32'h0, r);
    wr({3'h0, REG_MODE}, 32'h2, r);
    repeat (3) @(posedge aclk);
  endtask
  task automatic t_regs();
    chk({28'h0, ch_out[0]}, 32'h4);
    rd({3'h0, REG_BAND}, d, r);
    chk(d, 32'hA);
    wr({3'h0, REG_RESTART}, 32'h3FF, r);
    rd({3'h0, REG_RESTART}, d, r);
    chk(d, 32'h3E7);
    rd(8'h18, d, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    wr({3'h0, REG_STATUS}, 32'h1, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    wr({3'h0, REG_RESTART}, 32'h0, r);
  endtask
  task automatic t_break();
    arm(32'h4, 32'h4, 1'b0, 1'b1, OUT_FULL);
    chk({31'h0, ch_out[0].run}, 32'h1);
    watch(140, hit);
    chk({31'h0, hit}, 32'h1);
    chk({28'h0, ch_out[0]}, 32'h7);
    chk({31'h0, ch_out[1].led}, 32'h0);
    rd({3'h0, REG_STATUS}, d, r);
    chk({28'h0, d[3:0]}, 32'h9);
    wr({3'h0, REG_RESTART}, 32'h2, r);
    stuck <= 1'b0;
    wr({3'h0, REG_MODE}, 32'h2, r);
    watch(160, hit);
    chk({31'h0, ch_out[0].led}, 32'h1);
    chk({30'h0, fault_store}, 32'h1);
    fault_keep <= fault_store;
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    chk({31'h0, ch_out[0].led}, 32'h1);
    fault_keep <= 2'h0;
    wr({3'h0, REG_MODE}, 32'h2, r);
    repeat (3) @(posedge aclk);
    chk({31'h0, ch_out[0].led}, 32'h1);
    wr({3'h0, REG_MODE}, 32'h0, r);
    wr({3'h0, REG_MODE}, 32'h2, r);
    repeat (3) @(posedge aclk);
    chk({28'h0, ch_out[0]}, 32'h8);
  endtask
  task automatic t_move();
    arm(32'h4, 32'h4, 1'b0, 1'b0, OUT_FULL);
    watch(200, hit);
    chk({31'h0, hit}, 32'h0);
    lvl <= '0;
    watch(200, hit);
    chk({31'h0, hit}, 32'h0);
    arm(32'h5, 32'h4, 1'b0, 1'b0, OUT_FULL);
    watch(140, hit);
    chk({31'h0, hit}, 32'h1);
    arm(32'h5, 32'h4, 1'b1, 1'b0, OUT_FULL);
    watch(200, hit);
    chk({31'h0, hit}, 32'h0);
  endtask
  task automatic t_quiet();
    logic any;
    any = 1'b0;
    arm(32'h4, 32'h4, 1'b0, 1'b1, 10'h1F4);
    watch(200, hit);
    chk({31'h0, hit}, 32'h0);
    repeat (6)
    begin
      lvl <= (lvl == OUT_FULL) ? '0 : OUT_FULL;
      watch(50, hit);
      any = any | hit;
    end
    chk({31'h0, any}, 32'h0);
    arm(32'h4, 32'h0, 1'b0, 1'b1, OUT_FULL);
    watch(200, hit);
    chk({31'h0, hit}, 32'h0);
    arm(32'h6, 32'h4, 1'b0, 1'b1, OUT_FULL);
    watch(200, hit);
    chk({31'h0, hit}, 32'h0);
  endtask
  task automatic t_halt();
    arm(32'h4, 32'h0, 1'b0, 1'b1, OUT_FULL);
    wr({3'h0, REG_RESTART}, 32'h2, r);
    vld <= 1'b0;
    repeat (5) @(posedge aclk);
    chk({28'h0, ch_out[0]}, 32'h6);
    vld <= 1'b1;
    repeat (80) @(posedge aclk);
    chk({31'h0, ch_out[0].run}, 32'h1);
    wr({3'h0, REG_RESTART}, 32'h0, r);
    vld <= 1'b0;
    repeat (5) @(posedge aclk);
    vld <= 1'b1;
    repeat (80) @(posedge aclk);
    chk({31'h0, ch_out[0].run}, 32'h0);
    wr({3'h0, REG_MODE}, 32'h1, r);
    wr({3'h0, REG_MODE}, 32'h2, r);
    repeat (3) @(posedge aclk);
    chk({31'h0, ch_out[0].run}, 32'h1);
  endtask
  // free-running clock
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // cut a hang short
  initial
  begin
    repeat (20000) @(posedge aclk);
    err_total++;
    end_sim();
  end
  // main sequence
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, cool_p, stuck} = '0;
    {awaddr, araddr, wdata, fault_keep, lvl} = '0;
    wstrb = 4'hF;
    vld = 1'b1;
    aresetn = 1'b0;
    err_total = 0;
    compares = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_break();
    t_move();
    t_quiet();
    t_halt();
    end_sim();
  end
endmodule
`default_nettype wire
